// [tb_tpe_top.sv]
// Self-checking bench for the port expander top
`timescale 1ns/100ps
module tb_tpe_top;
    reg        clk;
    reg        reset_n;
    reg        bus_rst_n;
    reg        ce;
    reg  [1:0] sel_lo;
    reg  [1:0] sel_hi;
    reg  [7:0] dflt;
    reg  [7:0] pins;
    reg        ack;
    reg  [7:0] rd;
    wire       scl;
    wire       m_low;
    wire       sda_oe;
    wire       int_oe;
    wire [7:0] outs;
    wire [7:0] pulls;
    integer    errors;
    integer    tests_run;
    // Pulled-up line, low while either side pulls
    wire       sda = !(sda_oe || m_low);
    tpe_top i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe(sda_oe), .bus_rst_n(bus_rst_n), .addr_sel_low(sel_lo),
        .addr_sel_high(sel_hi), .out_default(dflt), .in_pins(pins), .out_pins(outs),
        .pullup_en(pulls), .int_out(), .int_oe(int_oe));
    tpe_ctl_model i_ctl (.scl(scl), .sda_low(m_low), .sda(sda));
    // --------
    // Helpers
    // --------
    task chk(input [7:0] seen, input [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task idle(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task chk_int(input e);
        chk({7'h00, int_oe}, {7'h00, e});
    endtask
    task wr(input [6:0] a, input [7:0] d0, input [7:0] d1, input e);
        i_ctl.start;
        i_ctl.wbyte({a, 1'b0}, ack);
        chk({7'h00, ack}, {7'h00, e});
        if (ack) begin
            i_ctl.wbyte(d0, ack);
            i_ctl.wbyte(d1, ack);
        end
        i_ctl.stop;
        idle(4);
    endtask
    // Short pulse: pin returns to 0x40 well before any read
    task pulse(input [7:0] v);
        pins = v;
        idle(2);
        pins = 8'h40;
        idle(8);
    endtask
    // --------
    // Scenarios
    // --------
    task t_por;
        chk(pulls, 8'hFF);
        chk_int(1'b0);
        chk(outs, 8'hA5);
    endtask
    task t_write;
        wr(7'h5D, 8'h5A, 8'h3C, 1'b1);
        chk(outs, 8'h3C);
        wr(7'h5C, 8'h00, 8'h00, 1'b0);
        wr(7'h3D, 8'h00, 8'h00, 1'b0);
        chk(outs, 8'h3C);
    endtask
    task t_flags;
        pulse(8'h40);
        chk_int(1'b1);
        wr(7'h6D, 8'h00, 8'hFE, 1'b1);
        chk_int(1'b0);
        pulse(8'h41);
        chk_int(1'b0);
        pulse(8'h42);
        chk_int(1'b1);
        i_ctl.start;
        i_ctl.wbyte({7'h6D, 1'b1}, ack);
        i_ctl.rbyte(1'b0, rd);
        chk(rd, 8'h40);
        i_ctl.rbyte(1'b1, rd);
        chk(rd, 8'h03);
        i_ctl.stop;
        idle(4);
        chk_int(1'b0);
    endtask
    task t_busrst;
        i_ctl.start;
        i_ctl.wbyte({7'h5D, 1'b1}, ack);
        idle(4);
        chk({7'h00, sda_oe}, 8'h01);
        pulse(8'h44);
        chk_int(1'b1);
        bus_rst_n = 1'b0;
        idle(10);
        chk({7'h00, sda_oe}, 8'h00);
        chk_int(1'b1);
        bus_rst_n = 1'b1;
        idle(4);
        i_ctl.stop;
        wr(7'h5D, 8'h00, 8'h99, 1'b1);
        chk(outs, 8'h99);
        chk_int(1'b0);
    endtask
    task t_strap;
        sel_lo = 2'h0;
        idle(8);
        chk(pulls, 8'hF0);
        sel_hi = 2'h0;
        idle(8);
        chk(pulls, 8'h00);
        wr(7'h58, 8'h00, 8'h24, 1'b1);
        chk(outs, 8'h24);
        sel_lo = 2'h2;
        sel_hi = 2'h3;
        idle(8);
        chk(pulls, 8'hFF);
        wr(7'h56, 8'h00, 8'h81, 1'b1);
        chk(outs, 8'h81);
    endtask
    // Low enable freezes sampling, so the change shows only once it rises
    task t_freeze;
        ce = 1'b0;
        pins = 8'h48;
        idle(8);
        chk_int(1'b0);
        ce = 1'b1;
        idle(8);
        chk_int(1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = !clk;
    end
    initial begin
        errors = 0;
        tests_run = 0;
        reset_n = 1'b0;
        bus_rst_n = 1'b1;
        ce = 1'b1;
        sel_lo = 2'h1;
        sel_hi = 2'h1;
        dflt = 8'hA5;
        pins = 8'h00;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        idle(8);
        t_por;
        t_write;
        t_flags;
        t_busrst;
        t_strap;
        t_freeze;
        close_out;
    end
    initial begin
        repeat (60000) @(posedge clk);
        errors = errors + 1;
        close_out;
    end
endmodule

// [tpe_ctl_model.sv]
// Behavioural bus controller: drives SCL and pulls SDA low
`timescale 1ns/100ps
module tpe_ctl_model (
    output reg  scl,
    output reg  sda_low,
    input  wire sda
);
    // --------
    // Bit timing
    // --------
    localparam Q = 50;
    reg     s;
    integer i;
    // Clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task start;
        sda_low = 1'b1;
        #(2*Q);
        scl = 1'b0;
        #Q;
    endtask
    task stop;
        sda_low = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sda_low = 1'b0;
        #(2*Q);
    endtask
    // Data changes a quarter after the fall, so hold time is kept
    task bit_io(input b, output v);
        sda_low = !b;
        #Q;
        scl = 1'b1;
        #(2*Q);
        v = sda;
        scl = 1'b0;
        #Q;
    endtask
    task wbyte(input [7:0] d, output ak);
        for (i = 7; i >= 0; i = i - 1)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ak = !s;
    endtask
    task rbyte(input nack, output [7:0] d);
        for (i = 7; i >= 0; i = i - 1) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(nack, s);
    endtask
endmodule

// [tpe_regs.vh]
// Constants of the two-address port expander
`ifndef TPE_REGS_VH
`define TPE_REGS_VH
// ----------------------------------------------------------------
// Target address prefixes (upper three address bits)
// ----------------------------------------------------------------
`define TPE_PFX_OUT      3'h5
`define TPE_PFX_IN       3'h6
// ----------------------------------------------------------------
// Address-select strap codes
// ----------------------------------------------------------------
`define TPE_AD_GND       2'h0
`define TPE_AD_VCC       2'h1
`define TPE_AD_SCL       2'h2
`define TPE_AD_SDA       2'h3
// ----------------------------------------------------------------
// Reset values and bus timing
// ----------------------------------------------------------------
`define TPE_MASK_RST     8'hFF
`define TPE_FLAG_RST     8'h00
`define TPE_BITS         4'h8
`define TPE_CLK_KHZ      40000
`define TPE_SCL_MAX_KHZ  400
`define TPE_OVERSAMPLE   (`TPE_CLK_KHZ / `TPE_SCL_MAX_KHZ)
`endif

// [tpe_sync.v]
// Two-flop level synchroniser, one bit per lane
`timescale 1ns/100ps
module tpe_sync #(
    parameter         W       = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    clk,
    reset_n,
    ce,
    d,
    q
);
    input  wire         clk;
    input  wire         reset_n;
    input  wire         ce;
    input  wire [W-1:0] d;
    output reg  [W-1:0] q;

    reg [W-1:0] meta_r;

    // Reset level chosen per instance to match the idle level of its pins
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// [tpe_top.v]
// Serial-bus port expander: 8 outputs, 8 monitored inputs, two targets
//
// Overview of operation
// - The output port answers at address 101xxxx and the input port at 110xxxx.
// - The low four address bits come from the two four-level address-select straps.
// - The bus runs up to 400kHz and the controller must not clock it faster; the bench controller model clocks it at 5MHz.
// - A low bus-reset pin returns the serial engine to idle and drops any transfer.
// - All eight inputs are sampled every cycle that ce is high, bus activity or not.
// - Each input owns a transition flag set when its level changes.
// - All flags clear when a transaction addressed to this device takes place.
// - A flag stays set until cleared, so short pulses are still reported.
// - An eight-bit mask selects which flags may drive the interrupt.
// - Eight push-pull outputs start from selectable default levels.
// - Input pull-ups are enabled or disabled by the address-select straps.
// - After power-on reset the mask is all ones and all flags are clear.
// - The bus-reset pin leaves the interrupt untouched.
// - The low strap controls pull-ups on inputs 0-3, the high strap inputs 4-7.
`timescale 1ns/100ps
`include "tpe_regs.vh"
module tpe_top (
    clk,
    reset_n,
    ce,
    scl_in,
    sda_in,
    sda_out,
    sda_oe,
    bus_rst_n,
    addr_sel_low,
    addr_sel_high,
    out_default,
    in_pins,
    out_pins,
    pullup_en,
    int_out,
    int_oe
);
    input  wire       clk;
    input  wire       reset_n;
    input  wire       ce;
    input  wire       scl_in;
    input  wire       sda_in;
    output wire       sda_out;
    output wire       sda_oe;
    input  wire       bus_rst_n;
    input  wire [1:0] addr_sel_low;
    input  wire [1:0] addr_sel_high;
    input  wire [7:0] out_default;
    input  wire [7:0] in_pins;
    output wire [7:0] out_pins;
    output wire [7:0] pullup_en;
    output wire       int_out;
    output wire       int_oe;

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_ADDR  = 7'h02;
    localparam [6:0] ST_ACKA  = 7'h04;
    localparam [6:0] ST_WRITE = 7'h08;
    localparam [6:0] ST_ACKW  = 7'h10;
    localparam [6:0] ST_READ  = 7'h20;
    localparam [6:0] ST_ACKR  = 7'h40;

    // Strap counts as selecting pull-ups unless tied to ground
    function grp_pull;
        input [1:0] code;
        begin
            grp_pull = (code != `TPE_AD_GND);
        end
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    wire [7:0] in_s;
    wire [3:0] ad_s;
    wire       scl_s;
    wire       sda_s;
    wire       brst_n_s;

    tpe_sync #(.W(8), .RST_VAL(8'h00)) u_sync_in (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .d       (in_pins),
        .q       (in_s)
    );

    // Straps read as high until sensed, matching the power-up pull-up state
    tpe_sync #(.W(7), .RST_VAL(7'h7F)) u_sync_bus (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .d       ({addr_sel_high, addr_sel_low, scl_in, sda_in, bus_rst_n}),
        .q       ({ad_s, scl_s, sda_s, brst_n_s})
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [6:0] state_r;
    reg  [3:0] cnt_r;
    reg  [7:0] sh_r;
    reg  [7:0] tx_r;
    reg        sda_oe_r;
    reg        is_in_r;
    reg        rd_r;
    reg        sel_flag_r;
    reg        got_ack_r;
    reg        scl_d_r;
    reg        sda_d_r;
    reg  [7:0] prev_in_r;
    reg  [7:0] flags_r;
    reg  [7:0] snap_r;
    reg  [7:0] mask_r;
    reg  [7:0] out_r;
    reg  [1:0] init_r;
    reg        int_oe_r;
    reg  [7:0] pull_r;
    reg        hit_r;

    // Sampling at 40 MHz leaves 100 samples per bit at the top bus rate
    wire       scl_rise = scl_s & ~scl_d_r;
    wire       scl_fall = ~scl_s & scl_d_r;
    wire       bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire       bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
    wire [3:0] low_addr = {~ad_s[3], ad_s[2], ad_s[1:0]};
    wire       match_out = (sh_r[7:5] == `TPE_PFX_OUT) && (sh_r[4:1] == low_addr);
    wire       match_in = (sh_r[7:5] == `TPE_PFX_IN) && (sh_r[4:1] == low_addr);
    wire       byte_done = (cnt_r == `TPE_BITS);
    wire [7:0] chg = in_s ^ prev_in_r;
    wire [7:0] flags_nxt = (flags_r & ~{8{hit_r}}) | chg;
    wire [7:0] next_tx = is_in_r ? (sel_flag_r ? in_s : snap_r) : out_r;

    assign sda_out   = 1'b0;
    assign sda_oe    = sda_oe_r;
    assign out_pins  = out_r;
    assign pullup_en = pull_r;
    assign int_out   = 1'b0;
    assign int_oe    = int_oe_r;

    // ----------------------------------------------------------------
    // Transition detection, mask, outputs
    // ----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_in_r <= 8'h00;
            flags_r   <= `TPE_FLAG_RST;
            int_oe_r  <= 1'b0;
            pull_r    <= 8'hFF;
            init_r    <= 2'h0;
        end else if (ce) begin
            // Three settling cycles, so pins idling high raise no false flag
            prev_in_r <= in_s;
            flags_r   <= (init_r == 2'h3) ? flags_nxt : `TPE_FLAG_RST;
            init_r    <= (init_r == 2'h3) ? init_r : init_r + 2'h1;
            // Bus reset is not looked at here
            int_oe_r  <= (init_r == 2'h3) && |(flags_nxt & mask_r);
            pull_r    <= {{4{grp_pull(ad_s[3:2])}}, {4{grp_pull(ad_s[1:0])}}};
        end
    end

    // ----------------------------------------------------------------
    // Serial target engine
    // ----------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= ST_IDLE;
            cnt_r      <= 4'h0;
            sh_r       <= 8'h00;
            tx_r       <= 8'h00;
            sda_oe_r   <= 1'b0;
            is_in_r    <= 1'b0;
            rd_r       <= 1'b0;
            sel_flag_r <= 1'b0;
            got_ack_r  <= 1'b0;
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
            snap_r     <= 8'h00;
            mask_r     <= `TPE_MASK_RST;
            out_r      <= 8'h00;
            hit_r      <= 1'b0;
        end else if (ce) begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            hit_r   <= 1'b0;
            if (init_r == 2'h0) begin
                out_r <= out_default;
            end
            if (!brst_n_s) begin
                state_r  <= ST_IDLE;
                sda_oe_r <= 1'b0;
                cnt_r    <= 4'h0;
            end else if (bus_start) begin
                state_r  <= ST_ADDR;
                sda_oe_r <= 1'b0;
                cnt_r    <= 4'h0;
            end else if (bus_stop) begin
                state_r  <= ST_IDLE;
                sda_oe_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        cnt_r <= 4'h0;
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            sh_r  <= {sh_r[6:0], sda_s};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && byte_done) begin
                            if (match_out || match_in) begin
                                sda_oe_r <= 1'b1;
                                is_in_r  <= match_in;
                                rd_r     <= sh_r[0];
                                snap_r   <= flags_r;
                                hit_r    <= 1'b1;
                                state_r  <= ST_ACKA;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACKA: begin
                        if (scl_fall) begin
                            cnt_r <= 4'h0;
                            if (rd_r) begin
                                // First byte: pins for input port, levels for output
                                tx_r       <= is_in_r ? in_s : out_r;
                                sda_oe_r   <= ~(is_in_r ? in_s[7] : out_r[7]);
                                sel_flag_r <= 1'b0;
                                state_r    <= ST_READ;
                            end else begin
                                sda_oe_r <= 1'b0;
                                state_r  <= ST_WRITE;
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (scl_rise) begin
                            sh_r  <= {sh_r[6:0], sda_s};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && byte_done) begin
                            sda_oe_r <= 1'b1;
                            if (is_in_r) begin
                                mask_r <= sh_r;
                            end else begin
                                out_r <= sh_r;
                            end
                            state_r <= ST_ACKW;
                        end
                    end
                    ST_ACKW: begin
                        if (scl_fall) begin
                            sda_oe_r <= 1'b0;
                            cnt_r    <= 4'h0;
                            state_r  <= ST_WRITE;
                        end
                    end
                    ST_READ: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (byte_done) begin
                                sda_oe_r  <= 1'b0;
                                got_ack_r <= 1'b0;
                                state_r   <= ST_ACKR;
                            end else begin
                                tx_r     <= {tx_r[6:0], 1'b0};
                                sda_oe_r <= ~tx_r[6];
                            end
                        end
                    end
                    ST_ACKR: begin
                        if (scl_rise) begin
                            got_ack_r <= ~sda_s;
                        end else if (scl_fall) begin
                            if (got_ack_r) begin
                                // Input port alternates flag snapshot and pin levels
                                tx_r       <= next_tx;
                                sda_oe_r   <= ~next_tx[7];
                                sel_flag_r <= ~sel_flag_r;
                                cnt_r      <= 4'h0;
                                state_r    <= ST_READ;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_r  <= ST_IDLE;
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// [tpe_top_chk.sv]
// Concurrent checks on the port expander top-level pins
`timescale 1ns/100ps
module tpe_top_chk (
    input wire       clk,
    input wire       reset_n,
    input wire       scl_in,
    input wire       bus_rst_n,
    input wire [1:0] addr_sel_low,
    input wire [1:0] addr_sel_high,
    input wire [7:0] in_pins,
    input wire [7:0] out_pins,
    input wire [7:0] pullup_en,
    input wire       sda_out,
    input wire       sda_oe,
    input wire       int_out,
    input wire       int_oe
);
    // --------
    // Pin relations
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_pull_lo;
        $stable(addr_sel_low) [*6] |-> pullup_en[3:0] == {4{addr_sel_low != 2'h0}};
    endproperty
    a_pull_lo: assert property (p_pull_lo) else $error("low pull-up group wrong");
    property p_pull_hi;
        $stable(addr_sel_high) [*6] |-> pullup_en[7:4] == {4{addr_sel_high != 2'h0}};
    endproperty
    a_pull_hi: assert property (p_pull_hi) else $error("high pull-up group wrong");
    property p_sda_rst; !bus_rst_n [*4] |-> !sda_oe; endproperty
    a_sda_rst: assert property (p_sda_rst) else $error("sda held in bus reset");
    // Quiet inputs rule out a fresh flag, so any change would come from the reset pin
    property p_int_hold; (!bus_rst_n && $stable(in_pins)) [*8] |-> $stable(int_oe); endproperty
    a_int_hold: assert property (p_int_hold) else $error("bus reset moved int");
    property p_int_clr; $fell(int_oe) |-> sda_oe; endproperty
    a_int_clr: assert property (p_int_clr) else $error("int cleared without access");
    // Default capture at the first edge after reset is not a write
    property p_out_chg; $changed(out_pins) && $past(reset_n, 2) |-> ##[0:2] sda_oe; endproperty
    a_out_chg: assert property (p_out_chg) else $error("outputs moved without write");
    property p_sda_phase; $changed(sda_oe) |-> !scl_in || !bus_rst_n; endproperty
    a_sda_phase: assert property (p_sda_phase) else $error("sda moved in clock high");
    property p_por; $rose(reset_n) |-> !int_oe ##1 !int_oe; endproperty
    a_por: assert property (p_por) else $error("int set after reset");
    property p_od; !int_out && !sda_out; endproperty
    a_od: assert property (p_od) else $error("open-drain data not low");
endmodule
bind tpe_top tpe_top_chk i_chk (.clk(clk), .reset_n(reset_n), .scl_in(scl_in),
    .bus_rst_n(bus_rst_n), .addr_sel_low(addr_sel_low), .addr_sel_high(addr_sel_high),
    .in_pins(in_pins), .out_pins(out_pins), .pullup_en(pullup_en), .sda_out(sda_out),
    .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe));
